// ==== rtl/feature_defines.svh ====
// offsets, field positions, codes and defaults of the feature-setting command handler
// What this block does
// - Opcode EF written after selector and count
// - Raise busy, capture selector, then interrupt
// - Unsupported or invalid selector aborts the command
// - 02 enables write cache, 82 disables
// - AA enables read cache, 55 disables
// - 05 enables power management, 85 disables
// - 66 keeps settings over soft reset, CC reverts on reset
// - BB selects four-byte long correction field
// - Selector 03: count is type and mode
// - Type codes: default, flow PIO, mDMA, UDMA
// - Only listed transfer codes accepted, others abort
// - Always runs PIO mode 4, DMA mode 2
// - 42 enables acoustic with count, C2 disables
// - Acoustic levels accepted only from 01 to FE
// - Acoustic state survives hard and soft reset; rst_b reloads it from the retained store
// - Acoustic level bands: quiet 80-BF, fast C0-FE
// - Acoustic disable reports level zero, flag clear
`ifndef FEATURE_DEFINES_SVH
`define FEATURE_DEFINES_SVH

// task-file byte addresses
`define ADDR_FEATURE_OR_FAULT 10'h1F1
`define ADDR_SECTOR_COUNT 10'h1F2
`define ADDR_SECTOR_NUMBER 10'h1F3
`define ADDR_CYLINDER_LOW 10'h1F4
`define ADDR_CYLINDER_HIGH 10'h1F5
`define ADDR_HEAD_SELECT 10'h1F6
`define ADDR_COMMAND_AND_FLAGS 10'h1F7

// command opcode and selector codes
`define OP_SET_FEATURES 8'hEF
`define SEL_WCACHE_ON 8'h02
`define SEL_WCACHE_OFF 8'h82
`define SEL_RCACHE_ON 8'hAA
`define SEL_RCACHE_OFF 8'h55
`define SEL_APM_ON 8'h05
`define SEL_APM_OFF 8'h85
`define SEL_KEEP 8'h66
`define SEL_REVERT 8'hCC
`define SEL_ECC4 8'hBB
`define SEL_XFER_MODE 8'h03
`define SEL_AAM_ON 8'h42
`define SEL_AAM_OFF 8'hC2

// transfer type codes and highest mode per type
`define XFER_PIO_DEFAULT 5'h00
`define XFER_PIO_FLOW 5'h01
`define XFER_MDMA 5'h04
`define XFER_UDMA 5'h08
`define XFER_PIO_FLOW_MAX 3'h4
`define XFER_MDMA_MAX 3'h2
`define XFER_UDMA_MAX 3'h5

// acoustic level limits
`define AAM_MIN 8'h01
`define AAM_MAX 8'hFE
`define AAM_QUIET_LO 8'h80
`define AAM_QUIET_HI 8'hBF

// flag and fault bit positions
`define STAT_BUSY_BIT 7
`define STAT_READY_BIT 6
`define STAT_SEEK_BIT 4
`define STAT_ERROR_BIT 0
`define FAULT_ABORT_BIT 2

// power-on defaults and fixed operating modes
`define WCACHE_DEFAULT 1'b1
`define RCACHE_DEFAULT 1'b1
`define APM_DEFAULT 1'b0
`define KEEP_DEFAULT 1'b0
`define PIO_MODE_FIXED 3'h4
`define DMA_MODE_FIXED 3'h2

`endif

// ==== rtl/feature_pkg.sv ====
// types shared by the feature-setting command handler
package feature_pkg;

   typedef enum logic [1:0] {
      CMD_IDLE = 2'b00,
      CMD_WAIT = 2'b01,
      CMD_EXEC = 2'b10
   } cmd_state_e;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_BAD = 4'h1,
      OP_WC_ON = 4'h2,
      OP_WC_OFF = 4'h3,
      OP_RC_ON = 4'h4,
      OP_RC_OFF = 4'h5,
      OP_APM_ON = 4'h6,
      OP_APM_OFF = 4'h7,
      OP_KEEP = 4'h8,
      OP_REVERT = 4'h9,
      OP_ECC4 = 4'hA,
      OP_XFER = 4'hB,
      OP_AAM_ON = 4'hC,
      OP_AAM_OFF = 4'hD
   } feat_op_e;

   typedef struct packed {
      feat_op_e op;
      logic quiet;
   } classify_s;

   typedef struct packed {
      cmd_state_e st;
      logic foreign;
      logic busy;
      logic intrq;
      logic err;
      logic [7:0] fault_report;
      logic [7:0] feature_selector;
      logic [7:0] sector_count;
      logic [7:0] sector_number;
      logic [7:0] cylinder_low;
      logic [7:0] cylinder_high;
      logic [7:0] head_select;
      logic wcache;
      logic rcache;
      logic apm;
      logic keep;
      logic ecc4;
      logic [7:0] xfer_code;
      logic aam_en;
      logic [7:0] aam_level;
      logic aam_quiet;
      logic [2:0] pio_mode;
      logic [2:0] dma_mode;
      logic loaded;
      logic [7:0] rd_data;
      logic rd_valid;
   } dev_s;

endpackage

// ==== rtl/feature_classify.sv ====
// registered decoder of the feature selector and sector count
`timescale 1ns/1ps
`include "feature_defines.svh"
module feature_classify (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] selector,
   input wire logic [7:0] count,
   output feature_pkg::feat_op_e op,
   output logic quiet
);
   import feature_pkg::*;

   classify_s c;
   classify_s next_c;
   logic [4:0] xtype;
   logic [2:0] xmode;
   logic xfer_legal;
   logic level_legal;

   // split the count into transfer type and mode number
   assign xtype = count[7:3];
   assign xmode = count[2:0];
   assign xfer_legal = ((xtype == `XFER_PIO_DEFAULT) && (xmode == 3'h0)) ||
                       ((xtype == `XFER_PIO_FLOW) && (xmode <= `XFER_PIO_FLOW_MAX)) ||
                       ((xtype == `XFER_MDMA) && (xmode <= `XFER_MDMA_MAX)) ||
                       ((xtype == `XFER_UDMA) && (xmode <= `XFER_UDMA_MAX));
   assign level_legal = (count >= `AAM_MIN) && (count <= `AAM_MAX);

   // map the selector to one operation; anything unlisted aborts
   always_comb begin
      next_c = c;
      next_c.quiet = (count >= `AAM_QUIET_LO) && (count <= `AAM_QUIET_HI);
      case (selector)
         `SEL_WCACHE_ON: next_c.op = OP_WC_ON;
         `SEL_WCACHE_OFF: next_c.op = OP_WC_OFF;
         `SEL_RCACHE_ON: next_c.op = OP_RC_ON;
         `SEL_RCACHE_OFF: next_c.op = OP_RC_OFF;
         `SEL_APM_ON: next_c.op = OP_APM_ON;
         `SEL_APM_OFF: next_c.op = OP_APM_OFF;
         `SEL_KEEP: next_c.op = OP_KEEP;
         `SEL_REVERT: next_c.op = OP_REVERT;
         `SEL_ECC4: next_c.op = OP_ECC4;
         `SEL_XFER_MODE: next_c.op = xfer_legal ? OP_XFER : OP_BAD;
         `SEL_AAM_ON: next_c.op = level_legal ? OP_AAM_ON : OP_BAD;
         `SEL_AAM_OFF: next_c.op = OP_AAM_OFF;
         8'h04, 8'h33, 8'h54, 8'h77, 8'h81, 8'h84, 8'h88, 8'h89, 8'hAB: next_c.op = OP_NOP;
         default: next_c.op = OP_BAD;
      endcase
   end

   // one register stage keeps the compare tree off the command path
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         c <= classify_s'{op: OP_NOP, quiet: 1'b0};
      end else begin
         c <= next_c;
      end
   end

   assign op = c.op;
   assign quiet = c.quiet;
endmodule // feature_classify

// ==== rtl/feature_handler.sv ====
// feature-setting command handler behind the task-file registers
`timescale 1ns/1ps
`include "feature_defines.svh"
module feature_handler #(
   parameter int ADDR_W = 10
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic hard_reset,
   input wire logic soft_reset,
   input wire logic nv_aam_on,
   input wire logic [7:0] nv_aam_level,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic busy,
   output logic intrq,
   output logic write_cache_on,
   output logic read_cache_on,
   output logic apm_on,
   output logic keep_settings,
   output logic ecc4_long,
   output logic [7:0] xfer_code,
   output logic aam_on,
   output logic [7:0] aam_level,
   output logic aam_quiet,
   output logic [2:0] pio_mode,
   output logic [2:0] dma_mode
);
   import feature_pkg::*;

   localparam dev_s DEV_RESET = '{
      st: CMD_IDLE,
      wcache: `WCACHE_DEFAULT,
      rcache: `RCACHE_DEFAULT,
      apm: `APM_DEFAULT,
      keep: `KEEP_DEFAULT,
      pio_mode: `PIO_MODE_FIXED,
      dma_mode: `DMA_MODE_FIXED,
      default: '0
   };

   dev_s s;
   dev_s next_s;
   feat_op_e op;
   logic op_quiet;
   logic [7:0] flags_byte;
   logic exec_ok;

   //////////////////////////////////////////////////////////////////////////////
   // the task-file bytes are full byte addresses, so the port must reach 0x1F7
   if (ADDR_W < 10) begin : g_addr_check
      $error("feature_handler: ADDR_W must be at least 10");
   end

   // selector decode runs one cycle behind the captured registers
   feature_classify u_classify (
      .clk(clk),
      .rst_b(rst_b),
      .selector(s.feature_selector),
      .count(s.sector_count),
      .op(op),
      .quiet(op_quiet)
   );

   assign exec_ok = (s.st == CMD_EXEC) && !s.foreign;

   // condition flags: busy, ready, seek complete and error
   always_comb begin
      flags_byte = 8'h00;
      flags_byte[`STAT_BUSY_BIT] = s.busy;
      flags_byte[`STAT_READY_BIT] = !s.busy;
      flags_byte[`STAT_SEEK_BIT] = 1'b1;
      flags_byte[`STAT_ERROR_BIT] = s.err;
   end

   //////////////////////////////////////////////////////////////////////////////
   // next state: power-on load, register port, command sequence, resets
   always_comb begin
      next_s = s;
      next_s.rd_valid = 1'b0;

      // acoustic state comes back from the retained store one cycle after release
      if (!s.loaded) begin
         next_s.loaded = 1'b1;
         if (nv_aam_on && (nv_aam_level >= `AAM_MIN) && (nv_aam_level <= `AAM_MAX)) begin
            next_s.aam_en = 1'b1;
            next_s.aam_level = nv_aam_level;
            next_s.aam_quiet = (nv_aam_level >= `AAM_QUIET_LO) && (nv_aam_level <= `AAM_QUIET_HI);
         end else begin
            next_s.aam_en = 1'b0;
            next_s.aam_level = 8'h00;
            next_s.aam_quiet = 1'b0;
         end
      end

      // reads answer one cycle later; reading the flags acknowledges the interrupt
      if (rd_en) begin
         next_s.rd_valid = 1'b1;
         case (addr)
            ADDR_W'(`ADDR_FEATURE_OR_FAULT): next_s.rd_data = s.fault_report;
            ADDR_W'(`ADDR_SECTOR_COUNT): next_s.rd_data = s.sector_count;
            ADDR_W'(`ADDR_SECTOR_NUMBER): next_s.rd_data = s.sector_number;
            ADDR_W'(`ADDR_CYLINDER_LOW): next_s.rd_data = s.cylinder_low;
            ADDR_W'(`ADDR_CYLINDER_HIGH): next_s.rd_data = s.cylinder_high;
            ADDR_W'(`ADDR_HEAD_SELECT): next_s.rd_data = s.head_select;
            ADDR_W'(`ADDR_COMMAND_AND_FLAGS): begin
               next_s.rd_data = flags_byte;
               next_s.intrq = 1'b0;
            end
            default: next_s.rd_data = 8'h00;
         endcase
      end

      // writes are dropped while busy, as the host must not touch the file then
      if (wr_en && !s.busy) begin
         case (addr)
            ADDR_W'(`ADDR_FEATURE_OR_FAULT): next_s.feature_selector = wr_data;
            ADDR_W'(`ADDR_SECTOR_COUNT): next_s.sector_count = wr_data;
            ADDR_W'(`ADDR_SECTOR_NUMBER): next_s.sector_number = wr_data;
            ADDR_W'(`ADDR_CYLINDER_LOW): next_s.cylinder_low = wr_data;
            ADDR_W'(`ADDR_CYLINDER_HIGH): next_s.cylinder_high = wr_data;
            ADDR_W'(`ADDR_HEAD_SELECT): next_s.head_select = wr_data;
            ADDR_W'(`ADDR_COMMAND_AND_FLAGS): begin
               next_s.busy = 1'b1;
               next_s.intrq = 1'b0;
               next_s.err = 1'b0;
               next_s.fault_report = 8'h00;
               next_s.foreign = (wr_data != `OP_SET_FEATURES);
               next_s.st = (wr_data == `OP_SET_FEATURES) ? CMD_WAIT : CMD_EXEC;
            end
            default: ;
         endcase
      end

      // the wait state gives the decoder its cycle
      unique case (s.st)
         CMD_IDLE: ;
         CMD_WAIT: next_s.st = CMD_EXEC;
         CMD_EXEC: begin
            next_s.st = CMD_IDLE;
            next_s.busy = 1'b0;
            next_s.intrq = 1'b1; // set placed after the read clear, so it wins
            if (s.foreign || (op == OP_BAD)) begin
               next_s.err = 1'b1;
               next_s.fault_report[`FAULT_ABORT_BIT] = 1'b1;
            end else begin
               unique case (op)
                  OP_NOP: ;
                  OP_BAD: ;
                  OP_WC_ON: next_s.wcache = 1'b1;
                  OP_WC_OFF: next_s.wcache = 1'b0;
                  OP_RC_ON: next_s.rcache = 1'b1;
                  OP_RC_OFF: next_s.rcache = 1'b0;
                  OP_APM_ON: next_s.apm = 1'b1;
                  OP_APM_OFF: next_s.apm = 1'b0;
                  OP_KEEP: next_s.keep = 1'b1;
                  OP_REVERT: next_s.keep = 1'b0;
                  OP_ECC4: next_s.ecc4 = 1'b1;
                  OP_XFER: next_s.xfer_code = s.sector_count;
                  OP_AAM_ON: begin
                     next_s.aam_en = 1'b1;
                     next_s.aam_level = s.sector_count;
                     next_s.aam_quiet = op_quiet;
                  end
                  OP_AAM_OFF: begin
                     next_s.aam_en = 1'b0;
                     next_s.aam_level = 8'h00;
                     next_s.aam_quiet = 1'b0;
                  end
               endcase
            end
         end
         default: next_s.st = CMD_IDLE;
      endcase

      // either reset ends any command; acoustic fields are never touched here
      if (hard_reset || soft_reset) begin
         next_s.st = CMD_IDLE;
         next_s.busy = 1'b0;
         next_s.intrq = 1'b0;
         next_s.err = 1'b0;
         next_s.foreign = 1'b0;
         next_s.fault_report = 8'h00;
         if (hard_reset || !s.keep) begin
            next_s.wcache = `WCACHE_DEFAULT;
            next_s.rcache = `RCACHE_DEFAULT;
            next_s.apm = `APM_DEFAULT;
            next_s.ecc4 = 1'b0;
            next_s.xfer_code = 8'h00;
         end
         if (hard_reset) begin
            next_s.keep = `KEEP_DEFAULT;
         end
      end

      // the operating modes do not follow the transfer selection
      next_s.pio_mode = `PIO_MODE_FIXED;
      next_s.dma_mode = `DMA_MODE_FIXED;
   end

   // all handler state but the decoder's own register stage in one register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= DEV_RESET;
      end else begin
         s <= next_s;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign rd_data = s.rd_data;
   assign rd_valid = s.rd_valid;
   assign busy = s.busy;
   assign intrq = s.intrq;
   assign write_cache_on = s.wcache;
   assign read_cache_on = s.rcache;
   assign apm_on = s.apm;
   assign keep_settings = s.keep;
   assign ecc4_long = s.ecc4;
   assign xfer_code = s.xfer_code;
   assign aam_on = s.aam_en;
   assign aam_level = s.aam_level;
   assign aam_quiet = s.aam_quiet;
   assign pio_mode = s.pio_mode;
   assign dma_mode = s.dma_mode;

   //////////////////////////////////////////////////////////////////////////////
   // checks on the command sequence and the settings
   property p_cmd_sequence;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (wr_en && !busy && (addr == ADDR_W'(`ADDR_COMMAND_AND_FLAGS)) && (wr_data == `OP_SET_FEATURES))
      |=> busy && !intrq ##1 busy ##1 (!busy && intrq);
   endproperty
   a_cmd_sequence: assert property (p_cmd_sequence) else $error("busy/interrupt sequence wrong");

   property p_abort;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      ((s.st == CMD_EXEC) && (s.foreign || (op == OP_BAD)))
      |=> (s.err && s.fault_report[`FAULT_ABORT_BIT] && flags_byte[`STAT_ERROR_BIT] && intrq && !busy);
   endproperty
   a_abort: assert property (p_abort) else $error("abort not reported");

   property p_write_cache;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && ((op == OP_WC_ON) || (op == OP_WC_OFF))) |=> (write_cache_on == ($past(op) == OP_WC_ON)) && !s.err;
   endproperty
   a_write_cache: assert property (p_write_cache) else $error("write cache not set");

   property p_read_cache;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && ((op == OP_RC_ON) || (op == OP_RC_OFF))) |=> (read_cache_on == ($past(op) == OP_RC_ON));
   endproperty
   a_read_cache: assert property (p_read_cache) else $error("read cache not set");

   property p_power_mgmt;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && ((op == OP_APM_ON) || (op == OP_APM_OFF))) |=> (apm_on == ($past(op) == OP_APM_ON));
   endproperty
   a_power_mgmt: assert property (p_power_mgmt) else $error("power management not set");

   property p_soft_keep;
      @(posedge clk) disable iff (!rst_b)
      (soft_reset && !hard_reset && keep_settings) |=> $stable(write_cache_on) && $stable(read_cache_on);
   endproperty
   a_soft_keep: assert property (p_soft_keep) else $error("settings lost on soft reset");

   property p_ecc4;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && (op == OP_ECC4)) |=> ecc4_long && !s.err;
   endproperty
   a_ecc4: assert property (p_ecc4) else $error("long field size not set");

   property p_xfer;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && (op == OP_XFER)) |=> (xfer_code == $past(s.sector_count)) && !s.err && (pio_mode == 3'h4);
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer code not stored");

   property p_aam_on;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && (op == OP_AAM_ON)) |=> aam_on && (aam_level == $past(s.sector_count)) && !s.err;
   endproperty
   a_aam_on: assert property (p_aam_on) else $error("acoustic level not taken");

   property p_aam_range;
      @(posedge clk) disable iff (!rst_b)
      aam_on |-> (aam_level >= 8'h01) && (aam_level <= 8'hFE) &&
                 (aam_quiet == ((aam_level >= 8'h80) && (aam_level <= 8'hBF)));
   endproperty
   a_aam_range: assert property (p_aam_range) else $error("acoustic level out of range");

   property p_aam_retain;
      @(posedge clk) disable iff (!rst_b)
      ((hard_reset || soft_reset) && s.loaded) |=> $stable(aam_on) && $stable(aam_level);
   endproperty
   a_aam_retain: assert property (p_aam_retain) else $error("acoustic state lost on reset");

   property p_aam_off;
      @(posedge clk) disable iff (!rst_b || hard_reset || soft_reset)
      (exec_ok && (op == OP_AAM_OFF)) |=> !aam_on && (aam_level == 8'h00) && intrq;
   endproperty
   a_aam_off: assert property (p_aam_off) else $error("acoustic disable not reported");
endmodule // feature_handler

// ==== tb/host_model.sv ====
// host-side model that loads and reads the task-file registers
`timescale 1ns/1ps
`include "feature_defines.svh"
module host_model (
   input wire logic clk,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   output logic [9:0] addr,
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic rd_en
);
   initial begin
      addr = 10'h000;
      wr_en = 1'b0;
      wr_data = 8'h00;
      rd_en = 1'b0;
   end
   // write held over its taking edge; data flips after release so stale bytes never look valid
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // read strobe for one cycle; the answer is taken in the following cycle
   task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      ok = rd_valid;
      d = rd_data;
   endtask
   // selector and count always precede the opcode
   task automatic issue(input logic [7:0] sel, input logic [7:0] cnt, input logic [7:0] op);
      wr(`ADDR_FEATURE_OR_FAULT, sel);
      wr(`ADDR_SECTOR_COUNT, cnt);
      wr(`ADDR_COMMAND_AND_FLAGS, op);
   endtask
endmodule // host_model

// ==== tb/testbench.sv ====
// self-checking bench for the feature-setting command handler
`timescale 1ns/1ps
`include "feature_defines.svh"
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hard_reset = 1'b0;
   logic soft_reset = 1'b0;
   logic nv_aam_on = 1'b1;
   logic [7:0] nv_aam_level = 8'h90;
   logic [9:0] addr;
   logic wr_en, rd_en, rd_valid, busy, intrq, write_cache_on, read_cache_on, apm_on;
   logic keep_settings, ecc4_long, aam_on, aam_quiet;
   logic [7:0] wr_data, rd_data, xfer_code, aam_level;
   logic [2:0] pio_mode, dma_mode;
   int n_fail = 0;
   int n_tests = 0;
   wire [7:0] feats = {3'b000, write_cache_on, read_cache_on, apm_on, keep_settings, ecc4_long};
   always #5 clk = ~clk;
   host_model u_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .addr(addr), .wr_en(wr_en),
      .wr_data(wr_data), .rd_en(rd_en));
   feature_handler #(.ADDR_W(10)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
      .wr_data(wr_data), .rd_en(rd_en), .hard_reset(hard_reset), .soft_reset(soft_reset),
      .nv_aam_on(nv_aam_on), .nv_aam_level(nv_aam_level), .rd_data(rd_data), .rd_valid(rd_valid),
      .busy(busy), .intrq(intrq), .write_cache_on(write_cache_on), .read_cache_on(read_cache_on),
      .apm_on(apm_on), .keep_settings(keep_settings), .ecc4_long(ecc4_long), .xfer_code(xfer_code),
      .aam_on(aam_on), .aam_level(aam_level), .aam_quiet(aam_quiet), .pio_mode(pio_mode),
      .dma_mode(dma_mode));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      logic ok;
      u_host.rd(a, d, ok);
      chk("rd_valid", 8'h01, {7'b0, ok});
   endtask
   // one command with the three-cycle completion (two for a foreign opcode) and the closing flag read
   task automatic cmd(input logic [7:0] sel, input logic [7:0] cnt, input logic [7:0] op, input logic bad);
      logic [7:0] d;
      u_host.issue(sel, cnt, op);
      chk("busy first", 8'h01, {7'b0, busy});
      // a foreign opcode skips the decode wait, so it ends one cycle sooner
      if (op == `OP_SET_FEATURES) begin
         @(posedge clk);
         #1;
         chk("busy second", 8'h01, {7'b0, busy});
      end
      @(posedge clk);
      #1;
      chk("busy intrq", 8'h01, {6'b0, busy, intrq});
      rd(`ADDR_FEATURE_OR_FAULT, d);
      chk("fault", bad ? 8'h04 : 8'h00, d);
      rd(`ADDR_COMMAND_AND_FLAGS, d);
      chk("flags", {7'h28, bad}, d);
      chk("intrq", 8'h00, {7'b0, intrq});
   endtask
   task automatic pulse(input logic hard);
      @(posedge clk);
      #1;
      hard_reset = hard;
      soft_reset = ~hard;
      @(posedge clk);
      #1;
      hard_reset = 1'b0;
      soft_reset = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("feats", 8'h18, feats);
      chk("modes", 8'h42, {1'b0, pio_mode, 1'b0, dma_mode});
      chk("idle", 8'h00, {6'b0, busy, intrq});
      chk("aam level", 8'h90, aam_level);
      chk("aam flags", 8'h03, {6'b0, aam_on, aam_quiet});
      $display("test reset finished");
   endtask
   // each selector followed by the feature set it must leave behind
   task automatic t_feats;
      logic [15:0] tbl [11] = '{16'h8208, 16'h0218, 16'h5510, 16'hAA18, 16'h051C, 16'h8518,
         16'hBB19, 16'h661B, 16'hCC19, 16'h3319, 16'h9919};
      foreach (tbl[i]) begin
         cmd(tbl[i][15:8], 8'h00, `OP_SET_FEATURES, tbl[i][15:8] == 8'h99);
         chk("feats", tbl[i][7:0], feats);
      end
      cmd(8'h82, 8'h00, 8'hEC, 1'b1);
      chk("feats", 8'h19, feats);
      $display("test feats finished");
   endtask
   task automatic t_xfer;
      logic [7:0] ok [7] = '{8'h00, 8'h08, 8'h0C, 8'h20, 8'h22, 8'h40, 8'h45};
      logic [7:0] no [6] = '{8'h01, 8'h0D, 8'h1F, 8'h23, 8'h46, 8'hFF};
      foreach (ok[i]) begin
         cmd(`SEL_XFER_MODE, ok[i], `OP_SET_FEATURES, 1'b0);
         chk("xfer", ok[i], xfer_code);
         chk("modes", 8'h42, {1'b0, pio_mode, 1'b0, dma_mode});
      end
      foreach (no[i]) begin
         cmd(`SEL_XFER_MODE, no[i], `OP_SET_FEATURES, 1'b1);
         chk("xfer", 8'h45, xfer_code);
      end
      $display("test xfer finished");
   endtask
   // count, then {quiet, on, abort} expected, then expected level; an abort leaves all as it was
   task automatic t_aam;
      logic [19:0] tbl [7] = '{20'hC52C5, 20'h003C5, 20'h80680, 20'hFF780, 20'hBF6BF, 20'hFE2FE,
         20'h01201};
      foreach (tbl[i]) begin
         cmd(`SEL_AAM_ON, tbl[i][19:12], `OP_SET_FEATURES, tbl[i][8]);
         chk("aam flags", {6'b0, tbl[i][9], tbl[i][10]}, {6'b0, aam_on, aam_quiet});
         chk("aam level", tbl[i][7:0], aam_level);
      end
      cmd(`SEL_AAM_OFF, 8'h00, `OP_SET_FEATURES, 1'b0);
      chk("aam off", 8'h00, {aam_level[7:1], aam_level[0] | aam_on});
      $display("test aam finished");
   endtask
   task automatic t_resets;
      cmd(`SEL_AAM_ON, 8'hA0, `OP_SET_FEATURES, 1'b0);
      cmd(`SEL_WCACHE_OFF, 8'h00, `OP_SET_FEATURES, 1'b0);
      cmd(`SEL_KEEP, 8'h00, `OP_SET_FEATURES, 1'b0);
      pulse(1'b0);
      chk("kept", 8'h0B, feats);
      cmd(`SEL_REVERT, 8'h00, `OP_SET_FEATURES, 1'b0);
      pulse(1'b0);
      chk("reverted", 8'h18, feats);
      chk("aam soft", 8'hA0, aam_on ? aam_level : 8'h00);
      cmd(`SEL_ECC4, 8'h00, `OP_SET_FEATURES, 1'b0);
      cmd(`SEL_XFER_MODE, 8'h0C, `OP_SET_FEATURES, 1'b0);
      pulse(1'b1);
      chk("hard", 8'h18, feats);
      chk("hard xfer", 8'h00, xfer_code);
      chk("aam hard", 8'hA0, aam_on ? aam_level : 8'h00);
      $display("test resets finished");
   endtask
   // plain registers read back; a write landing while busy is dropped
   task automatic t_regs;
      logic [7:0] d;
      for (int a = 3; a < 7; a++) begin
         u_host.wr(10'h1F0 + 10'(a), 8'h3C + 8'(a));
         rd(10'h1F0 + 10'(a), d);
         chk("reg", 8'h3C + 8'(a), d);
      end
      rd(10'h1F0, d);
      chk("unmapped", 8'h00, d);
      u_host.issue(8'h04, 8'h00, `OP_SET_FEATURES);
      u_host.wr(`ADDR_SECTOR_NUMBER, 8'h5A);
      rd(`ADDR_SECTOR_NUMBER, d);
      chk("busy drop", 8'h3F, d);
      rd(`ADDR_COMMAND_AND_FLAGS, d);
      chk("flags", 8'h50, d);
      $display("test regs finished");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("unexpected timeout: expected end, seen none");
      complete_run();
   end
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_feats();
      t_xfer();
      t_aam();
      t_resets();
      t_regs();
      complete_run();
   end
endmodule // testbench
